// >>> inc/rule_out_pkg.sv
// package: constants, types and register map of the rule output stage
package rule_out_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned NUM_FLAGS = 16;
  localparam int unsigned NUM_ICNT = 4;
  localparam int unsigned NUM_TMR = 4;
  localparam int unsigned ICNT_W = 16;
  localparam int unsigned TMR_W = 32;
  localparam int unsigned IRQ_W = 4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_VALUE = 8'h04;
  localparam logic [7:0] OFF_DESC = 8'h08;
  localparam logic [7:0] OFF_NAME = 8'h0c;
  localparam logic [7:0] OFF_NETADDR = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1c;
  localparam logic [7:0] OFF_ICNT_BASE = 8'h20;
  localparam logic [7:0] OFF_TMR_BASE = 8'h30;

  // ****************************************
  // field positions of the configuration word
  // ****************************************
  localparam int unsigned CFG_OP_LSB = 0;
  localparam int unsigned CFG_REMOTE_BIT = 4;
  localparam int unsigned CFG_LEVEL_BIT = 5;
  localparam int unsigned CFG_MODE_LSB = 6;
  localparam int unsigned CFG_TPOL_BIT = 8;
  localparam int unsigned CFG_CH_LSB = 12;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int unsigned IRQ_NOTICE = 0;
  localparam int unsigned IRQ_FLAG = 1;
  localparam int unsigned IRQ_ICNT = 2;
  localparam int unsigned IRQ_CYCLE = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [31:0] DESC_RST = 32'h0000_0000;
  localparam logic [31:0] NAME_RST = 32'h0000_0000;
  localparam logic [31:0] NETADDR_RST = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ANALOG = 4'h1, OP_DIGITAL = 4'h2, OP_DICNT = 4'h3,
    OP_PULSE = 4'h4, OP_TIMER = 4'h5, OP_FLAG = 4'h6, OP_NOTICE = 4'h7,
    OP_COUNTER = 4'h8
  } op_e;

  typedef enum logic [1:0] {
    DICNT_START = 2'h0, DICNT_STOP = 2'h1, DICNT_RESET = 2'h2, DICNT_NONE = 2'h3
  } dicnt_e;

  typedef enum logic [1:0] {
    PULSE_CONT = 2'h0, PULSE_FINITE = 2'h1, PULSE_STOP = 2'h2, PULSE_NONE = 2'h3
  } pulse_e;

  typedef struct packed {
    logic [3:0] index;
    logic level;
  } flag_wr_s;

  typedef struct packed {
    logic [31:0] description;
    logic [3:0] rule_num;
    logic [15:0] index;
    logic [31:0] net_addr;
    logic [31:0] name;
    logic [15:0] io_status;
  } notice_s;

  typedef struct packed {
    logic [3:0] channel;
    logic [15:0] value;
  } analog_cmd_s;

  typedef struct packed {
    logic [3:0] channel;
    dicnt_e cmd;
  } dicnt_cmd_s;

  typedef struct packed {
    logic [3:0] channel;
    pulse_e mode;
    logic [15:0] count;
  } pulse_cmd_s;

endpackage : rule_out_pkg

// >>> logic/rule_output_action_executor.sv
// rule output stage: performs the configured action on each rule result
//
// Overview of operation
// R01 - rule result writes local or remote flag
// R02 - true writes level, false writes complement
// R03 - notice sent only on true result
// R04 - notice carries configurable numeric index
// R05 - notice holds description, rule, index, address, name, io
// R06 - edge mode counts false-to-true transitions only
// R07 - reset mode clears counter on true
// R08 - channel index selects the internal counter
// R09 - analog true loads value, false keeps
// R10 - pulse true applies mode, false keeps
// R11 - timer counts on active polarity, else clears
// R12 - act once per rule cycle, remember result
`timescale 1ns/1ps

module rule_output_action_executor (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // rule result from the execution stage
  input wire logic RULE_STROBE,
  input wire logic RULE_RESULT,
  input wire logic [3:0] RULE_NUM,
  input wire logic [15:0] IO_STATUS,
  // remote flag write
  output logic FLAG_WR,
  output rule_out_pkg::flag_wr_s FLAG_WR_DATA,
  // network notice
  output logic NOTICE_SEND,
  output rule_out_pkg::notice_s NOTICE,
  // analog output, counter channel and pulse commands
  output logic DEST_REMOTE,
  output logic ANALOG_LOAD,
  output rule_out_pkg::analog_cmd_s ANALOG_CMD,
  output logic DICNT_WR,
  output rule_out_pkg::dicnt_cmd_s DICNT_CMD,
  output logic PULSE_WR,
  output rule_out_pkg::pulse_cmd_s PULSE_CMD,
  // local flags and interrupt
  output logic [15:0] FLAGS,
  output logic IRQ
);
  import rule_out_pkg::*;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [31:0] cfg;
  logic [15:0] value;
  logic [31:0] desc;
  logic [31:0] name;
  logic [31:0] net_addr;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] mask;
  logic prev_result;
  logic [NUM_FLAGS-1:0] flags;
  logic [ICNT_W-1:0] icnt [NUM_ICNT];
  logic [TMR_W-1:0] tmr [NUM_TMR];
  logic tmr_run [NUM_TMR];

  // field decode of the configuration word
  wire op_e op = op_e'(cfg[CFG_OP_LSB +: 4]);
  wire cfg_remote = cfg[CFG_REMOTE_BIT];
  wire cfg_level = cfg[CFG_LEVEL_BIT];
  wire [1:0] cfg_mode = cfg[CFG_MODE_LSB +: 2];
  wire cfg_tpol = cfg[CFG_TPOL_BIT];
  wire [3:0] cfg_ch = cfg[CFG_CH_LSB +: 4];

  // ****************************************
  // register port decode
  // ****************************************
  // one select per address, shared by the write and the read path except sel_flags, which only the read path uses
  wire sel_cfg = (ADDR == OFF_CFG);
  wire sel_value = (ADDR == OFF_VALUE);
  wire sel_desc = (ADDR == OFF_DESC);
  wire sel_name = (ADDR == OFF_NAME);
  wire sel_netaddr = (ADDR == OFF_NETADDR);
  wire sel_flags = (ADDR == OFF_FLAGS);
  wire sel_status = (ADDR == OFF_STATUS);
  wire sel_mask = (ADDR == OFF_MASK);

  // write strokes; writes to read-only words fall through unused
  wire wr_cfg = WR && sel_cfg;
  wire wr_value = WR && sel_value;
  wire wr_desc = WR && sel_desc;
  wire wr_name = WR && sel_name;
  wire wr_netaddr = WR && sel_netaddr;
  wire wr_status = WR && sel_status;
  wire wr_mask = WR && sel_mask;

  // counter and timer windows: four aligned words each
  wire [1:0] icnt_sel = ADDR[3:2];
  wire [1:0] tmr_sel = ADDR[3:2];
  wire word_aligned = (ADDR[1:0] == 2'h0);
  wire is_icnt = (ADDR[7:4] == OFF_ICNT_BASE[7:4]) && word_aligned;
  wire is_tmr = (ADDR[7:4] == OFF_TMR_BASE[7:4]) && word_aligned;

  // narrow registers widened so that every read is one full word
  wire [31:0] value_word = {16'h0000, value};
  wire [31:0] flags_word = {16'h0000, flags};
  wire [31:0] status_word = {28'h0000000, status};
  wire [31:0] mask_word = {28'h0000000, mask};
  wire [31:0] icnt_word = {16'h0000, icnt[icnt_sel]};

  // read selection; unmapped addresses answer zero
  wire [31:0] rd_mux =
    sel_cfg ? cfg :
    sel_value ? value_word :
    sel_desc ? desc :
    sel_name ? name :
    sel_netaddr ? net_addr :
    sel_flags ? flags_word :
    sel_status ? status_word :
    sel_mask ? mask_word :
    is_icnt ? icnt_word :
    is_tmr ? tmr[tmr_sel] : 32'h0000_0000;

  // ****************************************
  // rule result qualifiers
  // ****************************************
  wire res_true = RULE_STROBE && RULE_RESULT;
  wire res_rise = res_true && !prev_result; // R06
  wire ch_icnt_ok = (cfg_ch < 4'(NUM_ICNT));
  wire ch_tmr_ok = (cfg_ch < 4'(NUM_TMR));
  wire flag_level = RULE_RESULT ? cfg_level : !cfg_level; // R02

  // flag action: every strobe writes, false writes the complement
  wire do_flag = RULE_STROBE && (op == OP_FLAG); // R01
  wire do_flag_local = do_flag && !cfg_remote;
  wire do_flag_remote = do_flag && cfg_remote;

  // notice, analog and pulse act on a true result and ignore false
  wire do_notice = res_true && (op == OP_NOTICE); // R03
  wire do_analog = res_true && (op == OP_ANALOG); // R09
  wire do_pulse = res_true && (op == OP_PULSE); // R10

  // timer takes every strobe: false is an action for it too
  wire do_timer = RULE_STROBE && (op == OP_TIMER) && ch_tmr_ok;

  // internal counter: edge mode leans on the remembered result, so a
  // long run of true results adds one only
  wire cnt_edge_mode = (cfg_mode[0] == 1'b0);
  wire do_icnt_inc = res_rise && (op == OP_COUNTER) && cnt_edge_mode; // R06
  wire do_icnt_clr = res_true && (op == OP_COUNTER) && !cnt_edge_mode; // R07
  wire do_icnt = (do_icnt_inc || do_icnt_clr) && ch_icnt_ok;

  // counter channel: false swaps start and stop, reset has no false action
  wire dicnt_e true_cmd = dicnt_e'(cfg_mode);
  wire dicnt_e false_cmd =
    (true_cmd == DICNT_START) ? DICNT_STOP :
    (true_cmd == DICNT_STOP) ? DICNT_START : DICNT_NONE;
  wire dicnt_e dicnt_cmd = RULE_RESULT ? true_cmd : false_cmd;
  wire do_dicnt = RULE_STROBE && (op == OP_DICNT) && (dicnt_cmd != DICNT_NONE);

  // command images; each output register loads only when its action fires
  wire analog_cmd_s analog_next = '{channel: cfg_ch, value: value};
  wire dicnt_cmd_s dicnt_next = '{channel: cfg_ch, cmd: dicnt_cmd};
  wire pulse_ok = (cfg_mode != PULSE_NONE);
  wire pulse_e pulse_mode = pulse_e'(cfg_mode);
  wire pulse_cmd_s pulse_next =
    '{channel: cfg_ch, mode: pulse_mode, count: value};
  wire do_pulse_cmd = do_pulse && pulse_ok; // R10

  // notice image from live registers and the strobe's own inputs
  wire notice_s notice_next = '{
    description: desc,
    rule_num: RULE_NUM,
    index: value, // R04
    net_addr: net_addr,
    name: name,
    io_status: IO_STATUS // R05
  };

  // ****************************************
  // interrupt status: events set, write of one clears, set wins
  // ****************************************
  // an event and a clear in one cycle leave the bit set
  wire [IRQ_W-1:0] events;
  assign events[IRQ_NOTICE] = do_notice;
  assign events[IRQ_FLAG] = do_flag;
  assign events[IRQ_ICNT] = do_icnt;
  assign events[IRQ_CYCLE] = RULE_STROBE;
  wire [IRQ_W-1:0] clr_bits = wr_status ? WDATA[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_status = (status & ~clr_bits) | events;
  wire [IRQ_W-1:0] next_mask = wr_mask ? WDATA[IRQ_W-1:0] : mask;

  // ****************************************
  // configuration storage
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cfg <= CFG_RST;
      value <= VALUE_RST;
      desc <= DESC_RST;
      name <= NAME_RST;
      net_addr <= NETADDR_RST;
    end else begin
      if (wr_cfg) cfg <= WDATA;
      if (wr_value) value <= WDATA[15:0];
      if (wr_desc) desc <= WDATA;
      if (wr_name) name <= WDATA;
      if (wr_netaddr) net_addr <= WDATA;
    end
  end

  // status, mask and irq; irq is built from next values to line up
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      status <= '0;
      mask <= '0;
      IRQ <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      IRQ <= |(next_status & next_mask);
    end
  end

  // read data stand one cycle, then fall back to zero so a stale
  // word is never mistaken for a fresh answer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // result memory for edge detection
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      prev_result <= 1'b0;
    end else if (RULE_STROBE) begin
      prev_result <= RULE_RESULT; // R12
    end
  end

  // ****************************************
  // local and remote flags
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      flags <= '0;
      FLAG_WR <= 1'b0;
      FLAG_WR_DATA <= '0;
    end else begin
      if (do_flag_local) flags[cfg_ch] <= flag_level; // R01 R02
      FLAG_WR <= do_flag_remote; // R01
      if (do_flag_remote) begin
        FLAG_WR_DATA <= '{index: cfg_ch, level: flag_level}; // R02
      end
    end
  end

  // pin copy of the flag store; a rule reading it sees last cycle's
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLAGS <= '0;
    end else begin
      FLAGS <= flags;
    end
  end

  // ****************************************
  // network notice: fields frozen at the sending cycle
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      NOTICE_SEND <= 1'b0;
      NOTICE <= '0;
    end else begin
      NOTICE_SEND <= do_notice; // R03
      if (do_notice) begin
        NOTICE <= notice_next; // R04 R05
      end
    end
  end

  // ****************************************
  // analog, counter channel and pulse commands
  // ****************************************
  // commands hold their last value, so a false result keeps the analog and pulse outputs; counter channel start and stop swap on false
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DEST_REMOTE <= 1'b0;
      ANALOG_LOAD <= 1'b0;
      ANALOG_CMD <= '0;
      DICNT_WR <= 1'b0;
      DICNT_CMD <= '{channel: 4'h0, cmd: DICNT_NONE};
      PULSE_WR <= 1'b0;
      PULSE_CMD <= '{channel: 4'h0, mode: PULSE_NONE, count: 16'h0000};
    end else begin
      DEST_REMOTE <= cfg_remote;
      ANALOG_LOAD <= do_analog; // R09
      if (do_analog) ANALOG_CMD <= analog_next; // R09
      DICNT_WR <= do_dicnt;
      if (do_dicnt) DICNT_CMD <= dicnt_next;
      PULSE_WR <= do_pulse_cmd; // R10
      if (do_pulse_cmd) PULSE_CMD <= pulse_next; // R10
    end
  end

  // ****************************************
  // internal counters and timers, one slice per entry
  // ****************************************
  // timers tick every clock; the run flag only changes once per rule cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ICNT; gi++) begin : g_icnt
      wire hit = do_icnt && (cfg_ch[1:0] == 2'(gi)); // R08
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          icnt[gi] <= '0;
        end else if (hit && do_icnt_clr) begin
          icnt[gi] <= '0; // R07
        end else if (hit) begin
          icnt[gi] <= icnt[gi] + 1'b1; // R06
        end
      end
    end
    for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
      wire hit = do_timer && (cfg_ch[1:0] == 2'(gi));
      wire run_next = (RULE_RESULT == cfg_tpol);
      // a stopped timer reads zero; a running one wraps silently
      wire [TMR_W-1:0] tmr_next = tmr_run[gi] ? tmr[gi] + 1'b1 : '0;
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          tmr_run[gi] <= 1'b0;
          tmr[gi] <= '0;
        end else begin
          if (hit) tmr_run[gi] <= run_next; // R11
          tmr[gi] <= tmr_next; // R11
        end
      end
    end
  endgenerate

endmodule : rule_output_action_executor

// >>> testbench/rule_out_props.sv
// checker: port-level properties of the rule output stage
`timescale 1ns/1ps
module rule_out_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // rule result
  input wire logic RULE_STROBE,
  input wire logic RULE_RESULT,
  input wire logic [3:0] RULE_NUM,
  input wire logic [15:0] IO_STATUS,
  // actions
  input wire logic FLAG_WR,
  input wire logic NOTICE_SEND,
  input wire rule_out_pkg::notice_s NOTICE,
  input wire logic ANALOG_LOAD,
  input wire logic DICNT_WR,
  input wire logic PULSE_WR
);
  import rule_out_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // notices follow true results only, one per strobe
  notice_true_a: assert property (
    NOTICE_SEND |-> $past(RULE_STROBE && RULE_RESULT))
    else $error("notice sent without a true result");
  notice_once_a: assert property (
    NOTICE_SEND && !RULE_STROBE |=> !NOTICE_SEND)
    else $error("notice pulse longer than one cycle");
  notice_fields_a: assert property (
    NOTICE_SEND |-> NOTICE.rule_num == $past(RULE_NUM)
      && NOTICE.io_status == $past(IO_STATUS))
    else $error("notice fields not from the strobe");
  notice_hold_a: assert property (
    !NOTICE_SEND |-> $stable(NOTICE))
    else $error("notice contents moved without a send");
  // other actions need their own cause one cycle earlier
  analog_true_a: assert property (
    ANALOG_LOAD |-> $past(RULE_STROBE && RULE_RESULT))
    else $error("analog load without a true result");
  pulse_true_a: assert property (
    PULSE_WR |-> $past(RULE_STROBE && RULE_RESULT))
    else $error("pulse command without a true result");
  dicnt_cause_a: assert property (
    DICNT_WR |-> $past(RULE_STROBE))
    else $error("counter command without a strobe");
  flag_cause_a: assert property (
    FLAG_WR |-> $past(RULE_STROBE))
    else $error("flag write without a strobe");
  one_action_a: assert property (
    $onehot0({FLAG_WR, NOTICE_SEND, ANALOG_LOAD, DICNT_WR, PULSE_WR}))
    else $error("more than one action in a cycle");
endmodule : rule_out_props

// >>> testbench/remote_peer.sv
// partner: remote module that takes flag writes and notices
`timescale 1ns/1ps
module remote_peer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // traffic from the rule output stage
  input wire logic flag_wr,
  input wire rule_out_pkg::flag_wr_s flag_data,
  input wire logic notice_send,
  input wire rule_out_pkg::notice_s notice
);
  import rule_out_pkg::*;
  logic [15:0] flags;
  notice_s last;
  logic [7:0] count;
  // keep what arrives; count notices so extras are seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= 16'h0;
      last <= '0;
      count <= 8'h0;
    end else begin
      if (flag_wr) flags[flag_data.index] <= flag_data.level;
      if (notice_send) last <= notice;
      if (notice_send) count <= count + 8'h1;
    end
  end
endmodule : remote_peer

// >>> testbench/rule_output_action_executor_bench.sv
// bench: register and rule-result sequences for the rule output stage
`timescale 1ns/1ps
module rule_output_action_executor_bench;
  import rule_out_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic strobe = 1'b0;
  logic result = 1'b0;
  logic [3:0] rule_num = 4'h0;
  logic [15:0] io_status = 16'h0;
  logic [31:0] rdata, t, u;
  logic flag_wr, notice_send, analog_load, dicnt_wr, pulse_wr, irq, dest_remote;
  flag_wr_s flag_data;
  notice_s notice;
  analog_cmd_s analog_cmd;
  dicnt_cmd_s dicnt_cmd;
  pulse_cmd_s pulse_cmd;
  logic [15:0] flags;
  logic [4:0] pv;
  int fail_count = 0;
  int checked = 0;
  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  rule_output_action_executor dut_u (.REF_CLK(ref_clk), .RST(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RULE_STROBE(strobe), .RULE_RESULT(result), .RULE_NUM(rule_num),
    .IO_STATUS(io_status), .FLAG_WR(flag_wr), .FLAG_WR_DATA(flag_data),
    .NOTICE_SEND(notice_send), .NOTICE(notice), .DEST_REMOTE(dest_remote),
    .ANALOG_LOAD(analog_load), .ANALOG_CMD(analog_cmd),
    .DICNT_WR(dicnt_wr), .DICNT_CMD(dicnt_cmd), .PULSE_WR(pulse_wr),
    .PULSE_CMD(pulse_cmd), .FLAGS(flags), .IRQ(irq));
  remote_peer peer_u (.clk(ref_clk), .rst(rst), .flag_wr(flag_wr),
    .flag_data(flag_data), .notice_send(notice_send), .notice(notice));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic grab(input logic [7:0] a);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    t = rdata;
  endtask : grab
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    grab(a);
    chk(t, e);
  endtask : rreg
  // one rule cycle; action pulses are caught in the cycle they stand
  task automatic st(input logic r);
    @(posedge ref_clk);
    strobe <= 1'b1;
    result <= r;
    @(posedge ref_clk);
    strobe <= 1'b0;
    #1;
    pv = {flag_wr, notice_send, analog_load, dicnt_wr, pulse_wr};
  endtask : st
  // f holds {polarity, mode, level, remote}
  function automatic logic [31:0] cw(input logic [3:0] op,
    input logic [3:0] ch, input logic [4:0] f);
    cw = {16'h0, ch, 3'h0, f, op};
  endfunction : cw
  task automatic print_verdict;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // watchdog so a stuck sequence still reaches the verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rreg(OFF_CFG, CFG_RST);
    rreg(8'h40, 32'h0);
    chk({dicnt_cmd.cmd, pulse_cmd.mode}, 32'hf);
    $display("reset test done");
    wreg(OFF_CFG, cw(4'h6, 4'h3, 5'h02));
    st(1'b1);
    rreg(OFF_FLAGS, 32'h8);
    chk(flags, 32'h8);
    chk(dest_remote, 32'h0);
    st(1'b0);
    rreg(OFF_FLAGS, 32'h0);
    wreg(OFF_CFG, cw(4'h6, 4'h5, 5'h01));
    st(1'b0);
    chk(pv, 32'h10);
    chk(flag_data, 32'h0b);
    chk(dest_remote, 32'h1);
    st(1'b1);
    chk(flag_data, 32'h0a);
    chk(peer_u.flags, 32'h20);
    $display("flag test done");
    wreg(OFF_DESC, 32'hd1d2d3d4);
    wreg(OFF_NAME, 32'h51525354);
    wreg(OFF_NETADDR, 32'h0a000002);
    wreg(OFF_VALUE, 32'h1234);
    wreg(OFF_CFG, cw(4'h7, 4'h0, 5'h01));
    rule_num <= 4'h9;
    io_status <= 16'hbeef;
    st(1'b0);
    chk(pv, 32'h0);
    st(1'b1);
    chk(pv, 32'h08);
    @(posedge ref_clk);
    #1;
    chk(peer_u.count, 32'h1);
    chk(peer_u.last.index, 32'h1234);
    chk(peer_u.last.description, 32'hd1d2d3d4);
    chk(peer_u.last.name, 32'h51525354);
    chk(peer_u.last.net_addr, 32'h0a000002);
    chk({peer_u.last.rule_num, peer_u.last.io_status}, 32'h9beef);
    chk(irq, 32'h0);
    wreg(OFF_MASK, 32'h1);
    @(posedge ref_clk);
    #1;
    chk(irq, 32'h1);
    wreg(OFF_STATUS, 32'h1);
    @(posedge ref_clk);
    #1;
    chk(irq, 32'h0);
    $display("notice test done");
    wreg(OFF_CFG, cw(4'h8, 4'h2, 5'h00));
    for (int i = 0; i < 5; i++) st(1'(5'b10110 >> i));
    rreg(8'h28, 32'h2);
    rreg(8'h20, 32'h0);
    wreg(OFF_CFG, cw(4'h8, 4'h2, 5'h04));
    st(1'b0);
    rreg(8'h28, 32'h2);
    st(1'b1);
    rreg(8'h28, 32'h0);
    $display("counter test done");
    wreg(OFF_VALUE, 32'h0abc);
    wreg(OFF_CFG, cw(4'h1, 4'h1, 5'h00));
    st(1'b0);
    chk(pv, 32'h0);
    st(1'b1);
    chk(analog_cmd, 32'h10abc);
    wreg(OFF_VALUE, 32'h7);
    for (int m = 0; m < 3; m++) begin
      wreg(OFF_CFG, cw(4'h4, 4'h2, {1'b0, m[1:0], 2'b0}));
      st(1'b1);
      chk(pulse_cmd, {4'h2, m[1:0], 16'h7});
      st(1'b0);
      chk(pv, 32'h0);
      wreg(OFF_CFG, cw(4'h3, 4'h1, {1'b0, m[1:0], 2'b0}));
      st(1'b1);
      chk(dicnt_cmd, {4'h1, m[1:0]});
      st(1'b0);
      chk(pv[1], 32'(m < 2));
      chk(dicnt_cmd, {4'h1, (m == 2) ? 2'h2 : (m[1:0] ^ 2'h1)});
    end
    $display("channel test done");
    wreg(OFF_CFG, cw(4'h5, 4'h1, 5'h10));
    st(1'b1);
    grab(8'h34);
    u = t;
    grab(8'h34);
    chk(t - u, 32'h2);
    chk(u != 32'h0, 32'h1);
    st(1'b0);
    rreg(8'h34, 32'h0);
    wreg(OFF_CFG, cw(4'h5, 4'h1, 5'h00));
    st(1'b1);
    rreg(8'h34, 32'h0);
    st(1'b0);
    grab(8'h34);
    chk(t != 32'h0, 32'h1);
    $display("timer test done");
    print_verdict();
  end
endmodule : rule_output_action_executor_bench
bind rule_output_action_executor rule_out_props props_u (.*);
